// ===== pbg_clock_gates.sv
// AXI4-Lite register slave holding the three bridge clock masks
// assumes one clock, async active-low reset, write protection from outside
`timescale 1ns/1ps
module pbg_clock_gates (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic write_protect,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output pbg_pkg::pbg_gates_s clk_gates
);
  import pbg_pkg::*;

  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] first_mask;
  logic [31:0] second_mask;
  logic [31:0] third_mask;
  pbg_sel_e wr_sel;
  pbg_sel_e rd_sel;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_commit;
  logic wr_allowed;
  logic wr_first;
  logic wr_second;
  logic wr_third;
  logic [1:0] next_bresp;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  pbg_gates_s next_gates;
  logic wr_done;
  logic rd_done;
  // per-peripheral gate fields, a one lets that clock run
  logic [2:0] gate_first_upper;
  logic [3:0] gate_first_lower;
  logic [5:0] gate_second;
  logic [4:0] gate_analog;
  logic [4:0] gate_basic_timers;
  logic [2:0] gate_control_timers;
  logic [5:0] gate_serial_units;
  logic gate_event_routing;
  logic gate_third_protection;

  // channel handshakes; ready low means an item is held
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign wr_commit = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  // answer taken by the master; frees the channels again
  assign wr_done = s_axi_bvalid & s_axi_bready;
  assign rd_done = s_axi_rvalid & s_axi_rready;

  // write decode and protection
  assign wr_sel = pbg_decode(wr_addr);
  assign wr_allowed = wr_commit & ~write_protect;
  assign wr_first = wr_allowed & (wr_sel == PBG_SEL_FIRST);
  assign wr_second = wr_allowed & (wr_sel == PBG_SEL_SECOND);
  assign wr_third = wr_allowed & (wr_sel == PBG_SEL_THIRD);
  assign next_bresp = (wr_sel == PBG_SEL_NONE) ? PBG_RESP_DECERR :
                      write_protect ? PBG_RESP_SLVERR : PBG_RESP_OKAY;

  // read decode; unassigned bits come back zero from the registers
  assign rd_sel = pbg_decode(s_axi_araddr);
  assign next_rdata = (rd_sel == PBG_SEL_FIRST) ? first_mask :
                      (rd_sel == PBG_SEL_SECOND) ? second_mask :
                      (rd_sel == PBG_SEL_THIRD) ? third_mask : 32'h00000000;
  assign next_rresp = (rd_sel == PBG_SEL_NONE) ? PBG_RESP_DECERR : PBG_RESP_OKAY;

  // mask registers; only implemented bits are writable
  pbg_mask_reg #(
    .RESET_VALUE(PBG_FIRST_RST),
    .WRITE_MASK(PBG_FIRST_WMASK)
  ) u_first (
    .core_clk(core_clk),
    .nrst(nrst),
    .wr_en(wr_first),
    .wdata(wr_data),
    .wstrb(wr_strb),
    .value(first_mask)
  );

  pbg_mask_reg #(
    .RESET_VALUE(PBG_SECOND_RST),
    .WRITE_MASK(PBG_SECOND_WMASK)
  ) u_second (
    .core_clk(core_clk),
    .nrst(nrst),
    .wr_en(wr_second),
    .wdata(wr_data),
    .wstrb(wr_strb),
    .value(second_mask)
  );

  pbg_mask_reg #(
    .RESET_VALUE(PBG_THIRD_RST),
    .WRITE_MASK(PBG_THIRD_WMASK)
  ) u_third (
    .core_clk(core_clk),
    .nrst(nrst),
    .wr_en(wr_third),
    .wdata(wr_data),
    .wstrb(wr_strb),
    .value(third_mask)
  );

  // first bridge: interrupt, calendar and watchdog above the system units
  assign gate_first_upper = first_mask[PBG_A_EXTERNAL_INTERRUPT_UNIT:PBG_A_WATCHDOG];
  assign gate_first_lower = first_mask[PBG_A_GENERIC_CLOCK_UNIT:PBG_A_FIRST_ACCESS_PROTECTION];

  // second bridge: six units, bit 6 unimplemented
  assign gate_second = second_mask[PBG_B_BUS_SERIAL:PBG_B_SECOND_ACCESS_PROTECTION];

  // third bridge: analog and touch, timers, serial units, events, protection
  assign gate_analog = third_mask[PBG_C_SOUND_PORT:PBG_C_INPUT_CONVERTER];
  assign gate_basic_timers = third_mask[PBG_C_INPUT_CONVERTER-1:PBG_C_BASIC_TIMER_LSB];
  assign gate_control_timers = third_mask[PBG_C_BASIC_TIMER_LSB-1:PBG_C_CONTROL_TIMER_LSB];
  assign gate_serial_units = third_mask[PBG_C_CONTROL_TIMER_LSB-1:PBG_C_SERIAL_UNIT_LSB];
  assign gate_event_routing = third_mask[PBG_C_EVENT_ROUTING_UNIT];
  assign gate_third_protection = third_mask[PBG_C_THIRD_ACCESS_PROTECTION];

  // gate enables packed for the bridges; a one runs the clock, a zero stops it
  assign next_gates = '{first_bridge: {gate_first_upper, gate_first_lower},
                        second_bridge: gate_second,
                        third_bridge: {gate_analog, gate_basic_timers, gate_control_timers,
                                       gate_serial_units, gate_event_routing, gate_third_protection}};

  // registered gate outputs, one cycle behind the masks
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clk_gates <= '{first_bridge: PBG_FIRST_RST[PBG_FIRST_W-1:0],
                     second_bridge: PBG_SECOND_RST[PBG_SECOND_W-1:0],
                     third_bridge: PBG_THIRD_RST[PBG_THIRD_W-1:0]};
    end else begin
      clk_gates <= next_gates;
    end
  end

  // write address capture
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      wr_addr <= 8'h00;
    end else if (aw_take) begin
      s_axi_awready <= 1'b0;
      wr_addr <= s_axi_awaddr;
    end else if (wr_done) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data capture, independent of the address
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_wready <= 1'b1;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else if (w_take) begin
      s_axi_wready <= 1'b0;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (wr_done) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response once both halves are held
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PBG_RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= next_bresp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel; one read outstanding
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= PBG_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (rd_done) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : pbg_clock_gates

// ===== pbg_clock_gates_properties.sv
// handshake and gate-output assertions for the bridge clock mask slave
// assumes it is bound to pbg_clock_gates and sees only its ports
`timescale 1ns/1ps
module pbg_clock_gates_properties (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pbg_pkg::pbg_gates_s clk_gates
);
  import pbg_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // write steps: both halves taken, then answer taken
  sequence s_aw_w;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  a_write_answer: assert property (s_aw_w |-> ##2 s_axi_bvalid)
    else $error("write answer not two cycles after request");
  a_b_release: assert property (s_b_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed after answer");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after request");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_decerr_zero: assert property (s_axi_rvalid && s_axi_rresp == PBG_RESP_DECERR |-> s_axi_rdata == 32'h00000000)
    else $error("unmapped read returned data");
  a_gates_okay: assert property ($changed(clk_gates) |-> $past(s_axi_bvalid) && $past(s_axi_bresp) == PBG_RESP_OKAY)
    else $error("gates changed without accepted write");
endmodule : pbg_clock_gates_properties

bind pbg_clock_gates pbg_clock_gates_properties u_props (.core_clk, .nrst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clk_gates);

// ===== pbg_mask_reg.sv
// one clock mask register with byte strobes and fixed writable bits
// assumes the caller has already applied decode and write protection
`timescale 1ns/1ps
module pbg_mask_reg #(
  parameter logic [31:0] RESET_VALUE = 32'h00000000,
  parameter logic [31:0] WRITE_MASK = 32'hFFFFFFFF
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic [31:0] value
);
  logic [31:0] lane_mask;
  logic [31:0] next_value;

  // byte enables widened to bits, limited to implemented positions
  assign lane_mask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}} & WRITE_MASK;
  assign next_value = (value & ~lane_mask) | (wdata & lane_mask);

  // storage; unassigned bits stay zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      value <= RESET_VALUE & WRITE_MASK; // unimplemented reset bits read zero
    end else if (wr_en) begin
      value <= next_value;
    end
  end
endmodule : pbg_mask_reg

// ===== pbg_pkg.sv
// constants, register map and carrier types for the peripheral bus clock gates
// assumes a 32-bit AXI4-Lite register bus and one system clock
package pbg_pkg;
  // register byte offsets
  localparam logic [7:0] PBG_FIRST_OFS = 8'h18;
  localparam logic [7:0] PBG_SECOND_OFS = 8'h1C;
  localparam logic [7:0] PBG_THIRD_OFS = 8'h20;
  // reset values, before the writable masks cut them
  localparam logic [31:0] PBG_FIRST_RST = 32'h0000007F;
  localparam logic [31:0] PBG_SECOND_RST = 32'h0000007F;
  localparam logic [31:0] PBG_THIRD_RST = 32'h00010000;
  // writable bit masks, all other positions read zero
  localparam logic [31:0] PBG_FIRST_WMASK = 32'h0000007F;
  localparam logic [31:0] PBG_SECOND_WMASK = 32'h0000003F;
  localparam logic [31:0] PBG_THIRD_WMASK = 32'h001FFFFF;
  // field positions, first bridge
  localparam int PBG_A_EXTERNAL_INTERRUPT_UNIT = 6;
  localparam int PBG_A_CALENDAR = 5;
  localparam int PBG_A_WATCHDOG = 4;
  localparam int PBG_A_GENERIC_CLOCK_UNIT = 3;
  localparam int PBG_A_SYSTEM_CONTROLLER = 2;
  localparam int PBG_A_POWER_MANAGER = 1;
  localparam int PBG_A_FIRST_ACCESS_PROTECTION = 0;
  // field positions, second bridge
  localparam int PBG_B_BUS_SERIAL = 5;
  localparam int PBG_B_MEMORY_TRANSFER_ENGINE = 4;
  localparam int PBG_B_PIN_PORT = 3;
  localparam int PBG_B_FLASH_CONTROLLER = 2;
  localparam int PBG_B_DEBUG_UNIT = 1;
  localparam int PBG_B_SECOND_ACCESS_PROTECTION = 0;
  // field positions, third bridge
  localparam int PBG_C_SOUND_PORT = 20;
  localparam int PBG_C_TOUCH_UNIT = 19;
  localparam int PBG_C_OUTPUT_CONVERTER = 18;
  localparam int PBG_C_COMPARATORS = 17;
  localparam int PBG_C_INPUT_CONVERTER = 16;
  localparam int PBG_C_BASIC_TIMER_LSB = 11;
  localparam int PBG_C_CONTROL_TIMER_LSB = 8;
  localparam int PBG_C_SERIAL_UNIT_LSB = 2;
  localparam int PBG_C_EVENT_ROUTING_UNIT = 1;
  localparam int PBG_C_THIRD_ACCESS_PROTECTION = 0;
  // field widths
  localparam int PBG_FIRST_W = 7;
  localparam int PBG_SECOND_W = 6;
  localparam int PBG_THIRD_W = 21;
  // AXI responses
  localparam logic [1:0] PBG_RESP_OKAY = 2'h0;
  localparam logic [1:0] PBG_RESP_SLVERR = 2'h2;
  localparam logic [1:0] PBG_RESP_DECERR = 2'h3;

  // clock enables toward the three bridges, one bit per peripheral
  typedef struct packed {
    logic [PBG_FIRST_W-1:0] first_bridge;
    logic [PBG_SECOND_W-1:0] second_bridge;
    logic [PBG_THIRD_W-1:0] third_bridge;
  } pbg_gates_s;

  // register select decoded from a byte address
  typedef enum logic [1:0] {
    PBG_SEL_NONE,
    PBG_SEL_FIRST,
    PBG_SEL_SECOND,
    PBG_SEL_THIRD
  } pbg_sel_e;

  // word-aligned decode of an offset
  function automatic pbg_sel_e pbg_decode(input logic [7:0] addr);
    pbg_sel_e sel;
    sel = PBG_SEL_NONE;
    if ({addr[7:2], 2'b00} == PBG_FIRST_OFS) sel = PBG_SEL_FIRST;
    if ({addr[7:2], 2'b00} == PBG_SECOND_OFS) sel = PBG_SEL_SECOND;
    if ({addr[7:2], 2'b00} == PBG_THIRD_OFS) sel = PBG_SEL_THIRD;
    return sel;
  endfunction : pbg_decode
endpackage : pbg_pkg

// ===== test_peripheral_bus_clock_gates.sv
// self-checking bench for the bridge clock mask registers
// assumes pbg_pkg and pbg_clock_gates are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module test_peripheral_bus_clock_gates;
  import pbg_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, write_protect = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  pbg_gates_s clk_gates;
  int n_errors = 0, check_count = 0;
  localparam logic [7:0] OFS [3] = '{PBG_FIRST_OFS, PBG_SECOND_OFS, PBG_THIRD_OFS};
  localparam logic [31:0] WM [3] = '{PBG_FIRST_WMASK, PBG_SECOND_WMASK, PBG_THIRD_WMASK};
  logic [31:0] m [3];
  wire pbg_gates_s exp_gates = {m[0][6:0], m[1][5:0], m[2][20:0]};

  pbg_clock_gates uut (.core_clk, .nrst, .write_protect, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .clk_gates);

  // 50 ns clock
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // one write, each channel held until its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er,
                    input int lag = 0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    if (lag != 0) begin
      repeat (lag) @(posedge core_clk);
      s_axi_bready <= 1'b1;
      @(posedge core_clk);
    end
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
    @(posedge core_clk);
  endtask : wr

  // one read, compared at the answer edge
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input int lag = 0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    if (lag != 0) begin
      repeat (lag) @(posedge core_clk);
      s_axi_rready <= 1'b1;
      @(posedge core_clk);
    end
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
    @(posedge core_clk);
  endtask : rd

  task automatic chk_all;
    for (int i = 0; i < 3; i++) rd(OFS[i], m[i], PBG_RESP_OKAY);
    `CHK(clk_gates, exp_gates)
  endtask : chk_all

  // masked write, model update, then read everything back
  task automatic mw(input int i, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] bm;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & WM[i];
    wr(OFS[i], d, s, PBG_RESP_OKAY);
    m[i] = (m[i] & ~bm) | (d & bm);
    chk_all;
  endtask : mw

  task automatic reset_model;
    m = '{PBG_FIRST_RST, PBG_SECOND_RST & PBG_SECOND_WMASK, PBG_THIRD_RST};
    chk_all;
  endtask : reset_model

  // main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    reset_model;
    $display("test reset values done");
    for (int i = 0; i < 3; i++) for (int b = 0; b < 21; b++) if (WM[i][b]) mw(i, 32'h1 << b, 4'hF);
    $display("test walking gates done");
    for (int i = 0; i < 3; i++) mw(i, 32'hFFFFFFFF, 4'hF);
    mw(2, 32'h00000000, 4'h4);
    $display("test reserved bits and strobes done");
    write_protect <= 1'b1;
    wr(OFS[1], 32'h00000000, 4'hF, PBG_RESP_SLVERR, 2);
    wr(OFS[2], 32'h00000000, 4'hF, PBG_RESP_SLVERR);
    write_protect <= 1'b0;
    wr(8'h24, 32'hFFFFFFFF, 4'hF, PBG_RESP_DECERR);
    rd(8'h00, 32'h00000000, PBG_RESP_DECERR, 2);
    chk_all;
    $display("test protection and unmapped done");
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    reset_model;
    $display("test second reset done");
    tally_and_finish;
  end

  // watchdog, about 4000 cycles
  initial begin
    #200us;
    n_errors++;
    tally_and_finish;
  end
endmodule : test_peripheral_bus_clock_gates
